// ===== src/phy_status_and_irq_enable.sv
// Link state summary, event enable, pending events and interrupt pin behind an APB slave.
//
// How it works
// - Bits 15:14 report speed: 00 ten, 01 hundred, 10 gigabit, 11 reserved.
// - Bit 13 reads one for full duplex, zero for half duplex.
// - Bit 12 latches on page received and clears when the summary is read.
// - Bit 11 reads one when negotiation is done or disabled.
// - Bit 10 shows live link up state.
// - Bit 9 shows crossover resolution of pairs C and D.
// - Bit 8 shows crossover resolution of pairs A and B.
// - Bit 7 shows gigabit masking, only while negotiation runs.
// - Bit 6 reads one while the device sleeps.
// - Bits 5:2 give channel polarity D..A while a gigabit link is up.
// - Bit 1 shows ten megabit polarity correct, resetting to one.
// - Bit 0 mirrors jabber and is not cleared by reading.
// - Jabber bit carries meaning only at ten megabit.
// - An event interrupts only when its enable bit is set.
// - Enable bits 15..10, 8, 6..0 gate the documented events, reset zero.
// - Pending bits set whatever the enable; reading them clears them.
// - Interrupt pin polarity bit resets to one, meaning active low.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module phy_status_and_irq_enable
    import phy_status_pkg::*;
(
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         resetn,
    // APB slave.
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // Transceiver core.
    input  wire live_status_t live,
    input  wire ext_events_t  extEv,
    // Interrupt.
    output logic              irq,
    output logic              intPin
);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Bus phase decode.
    logic        setupPh;
    logic        accessPh;
    logic [9:0]  regIdx;
    logic        addrOk;
    logic        wrLow;
    logic        wrHigh;
    assign setupPh  = psel && !penable;
    assign accessPh = psel && penable;
    assign regIdx   = paddr[11:2];
    assign addrOk   = (paddr[1:0] == 2'h0) &&
                      (regIdx == IDX_LINK_STATE || regIdx == IDX_IRQ_ENABLE ||
                       regIdx == IDX_EVENT_PEND || regIdx == IDX_IRQ_CONFIG);
    assign wrLow    = accessPh && pwrite && pstrb[0];
    assign wrHigh   = accessPh && pwrite && pstrb[1];
    assign pready   = 1'b1;

    // Register strobes; only the access phase commits anything.
    logic rdLink;
    logic rdPend;
    logic wrEnable;
    logic wrPend;
    logic wrConfig;
    assign rdLink   = accessPh && !pwrite && regIdx == IDX_LINK_STATE && addrOk;
    assign rdPend   = accessPh && !pwrite && regIdx == IDX_EVENT_PEND && addrOk;
    assign wrEnable = pwrite && accessPh && regIdx == IDX_IRQ_ENABLE && addrOk;
    assign wrPend   = pwrite && accessPh && regIdx == IDX_EVENT_PEND && addrOk;
    assign wrConfig = pwrite && accessPh && regIdx == IDX_IRQ_CONFIG && addrOk;

    // Byte lane mask built from the strobes.
    logic [15:0] laneMask;
    assign laneMask = {{8{wrHigh}}, {8{wrLow}}};

    // Registered, qualified copy of the live state.
    live_status_t statR;
    live_status_t statNxt;
    always_comb begin
        statNxt            = live;
        // Masking only means something while negotiation runs.
        statNxt.gigMasking = live.gigMasking && live.negRunning;
        // Channel polarity is only reported on an established gigabit link.
        statNxt.chanPolRev = (live.linkUp && live.rate == RATE_1G) ?
                             live.chanPolRev : 4'h0;
        // Jabber is forced off away from ten megabit so it cannot mislead.
        statNxt.jabber     = live.jabber && live.rate == RATE_10M;
    end

    // Sampled state; the polarity bit powers up as correct.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            statR         <= '0;
            statR.pol10Ok <= 1'b1;
        end else begin
            statR         <= statNxt;
        end
    end

    // Page received latch; a new page in the read cycle survives the clear.
    logic pageLatchR;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pageLatchR <= 1'b0;
        end else if (extEv.pageRx) begin
            pageLatchR <= 1'b1;
        end else if (rdLink) begin
            pageLatchR <= 1'b0;
        end
    end

    // Summary word as software sees it.
    logic [15:0] statusWord;
    always_comb begin
        statusWord                    = 16'h0000;
        statusWord[RATE_HI:RATE_LO]   = statR.rate;
        statusWord[DUPLEX_BIT]        = statR.fullDuplex;
        statusWord[PAGE_BIT]          = pageLatchR;
        statusWord[RESOLV_BIT]        = statR.negDone || !statR.negEnabled;
        statusWord[LINK_BIT]          = statR.linkUp;
        statusWord[XCD_BIT]           = statR.crossCd;
        statusWord[XAB_BIT]           = statR.crossAb;
        statusWord[GMASK_BIT]         = statR.gigMasking;
        statusWord[SLEEP_BIT]         = statR.asleep;
        statusWord[CHPOL_HI:CHPOL_LO] = statR.chanPolRev;
        statusWord[POL10_BIT]         = statR.pol10Ok;
        // Reading the summary leaves jabber alone, unlike the basic status copy.
        statusWord[JABBER_BIT]        = statR.jabber;
    end

    // Event detection: change events compare live state with the last sample.
    logic [15:0] evtVec;
    always_comb begin
        evtVec              = 16'h0000;
        evtVec[EV_NEG_ERR]  = extEv.negError;
        evtVec[EV_RATE]     = statNxt.rate != statR.rate;
        evtVec[EV_DUPLEX]   = statNxt.fullDuplex != statR.fullDuplex;
        evtVec[EV_PAGE]     = extEv.pageRx;
        evtVec[EV_NEG_DONE] = statNxt.negDone && !statR.negDone;
        evtVec[EV_LINK]     = statNxt.linkUp != statR.linkUp;
        evtVec[EV_FALSE_CS] = extEv.falseCarrier;
        evtVec[EV_CROSS]    = (statNxt.crossCd != statR.crossCd) ||
                              (statNxt.crossAb != statR.crossAb);
        evtVec[EV_DOWNSHFT] = extEv.downshift;
        evtVec[EV_DOZE]     = statNxt.asleep != statR.asleep;
        evtVec[EV_WAKE]     = extEv.wakePacket;
        evtVec[EV_MAC_ERR]  = extEv.macIfError;
        evtVec[EV_POLARITY] = (statNxt.pol10Ok != statR.pol10Ok) ||
                              (statNxt.chanPolRev != statR.chanPolRev);
        evtVec[EV_JABBER]   = statNxt.jabber && !statR.jabber;
    end

    // Enable register; reserved bits are held at zero by the write mask.
    logic [15:0] enableR;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            enableR <= ENABLE_RESET;
        end else if (wrEnable) begin
            enableR <= (enableR & ~(laneMask & ENABLE_WMASK)) |
                       (pwdata[15:0] & laneMask & ENABLE_WMASK);
        end
    end

    // Pending events, set whatever the enable; read or write-one clears.
    logic [15:0] pendR;
    logic [15:0] pendClr;
    assign pendClr = (rdPend ? 16'hffff : 16'h0000) |
                     (wrPend ? (pwdata[15:0] & laneMask) : 16'h0000);
    // Set takes priority over clear so an event in the clearing cycle stays.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pendR <= PEND_RESET;
        end else begin
            pendR <= (pendR & ~pendClr) | evtVec;
        end
    end

    // Interrupt configuration; only the polarity bit is writable.
    logic [15:0] configR;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            configR <= CONFIG_RESET;
        end else if (wrConfig) begin
            configR <= (configR & ~(laneMask & CONFIG_WMASK)) |
                       (pwdata[15:0] & laneMask & CONFIG_WMASK);
        end
    end

    // Level interrupt from enabled pending bits, plus the polarised pin.
    assign irq = |(pendR & enableR);
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            intPin <= 1'b1;
        end else begin
            intPin <= configR[INT_POL_BIT] ? !irq : irq;
        end
    end

    // Read data and error are captured in the setup phase so they are flop outputs
    // during access; the cost is that a read sees state one cycle older.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPh) begin
            pslverr <= !addrOk;
            prdata  <= 32'h0000_0000;
            if (addrOk && !pwrite) begin
                case (regIdx)
                    IDX_LINK_STATE: prdata[15:0] <= statusWord;
                    IDX_IRQ_ENABLE: prdata[15:0] <= enableR;
                    IDX_EVENT_PEND: prdata[15:0] <= pendR;
                    IDX_IRQ_CONFIG: prdata[15:0] <= configR;
                    default:        prdata[15:0] <= 16'h0000;
                endcase
            end
        end
    end

    // Speed field read in access phase reflects live rate two cycles back.
    rate_field_a: assert property (
        setupPh && !pwrite && regIdx == IDX_LINK_STATE && addrOk
        |=> prdata[15:14] == $past(live.rate, 2))
        else $error("rate field wrong");

    duplex_bit_a: assert property (
        setupPh && !pwrite && regIdx == IDX_LINK_STATE && addrOk
        |=> prdata[13] == $past(live.fullDuplex, 2))
        else $error("duplex bit wrong");

    page_latch_a: assert property (
        extEv.pageRx |=> statusWord[PAGE_BIT])
        else $error("page latch lost");

    page_clear_a: assert property (
        rdLink && !extEv.pageRx |=> !statusWord[PAGE_BIT])
        else $error("page bit not cleared by read");

    resolved_bit_a: assert property (
        resetn |=> statusWord[RESOLV_BIT] == $past(live.negDone || !live.negEnabled))
        else $error("resolution bit wrong");

    link_bit_a: assert property (
        $changed(live.linkUp) |=> statusWord[LINK_BIT] == $past(live.linkUp))
        else $error("link bit stale");

    chan_pol_a: assert property (
        !(live.linkUp && live.rate == RATE_1G) |=> statusWord[CHPOL_HI:CHPOL_LO] == 4'h0)
        else $error("channel polarity shown without gigabit link");

    jabber_keep_a: assert property (
        rdLink && statusWord[JABBER_BIT] && $past(statNxt.jabber) && statNxt.jabber
        |=> statusWord[JABBER_BIT])
        else $error("jabber cleared by read");

    enable_write_a: assert property (
        wrEnable && pstrb[1:0] == 2'h3 |=> enableR == ($past(pwdata[15:0]) & ENABLE_WMASK))
        else $error("enable write wrong");

    pend_set_a: assert property (
        |evtVec |=> (pendR & $past(evtVec)) == $past(evtVec))
        else $error("event not latched");

    irq_gate_a: assert property (
        (pendR & enableR) == 16'h0000 && evtVec == 16'h0000 && !wrEnable |=> !irq)
        else $error("interrupt without enabled event");

    int_pin_a: assert property (
        irq && configR[INT_POL_BIT] ##1 irq && configR[INT_POL_BIT] |-> !intPin)
        else $error("pin polarity wrong");

    // Live summary bits follow the state sampled one edge earlier.
    cross_cd_a: assert property (
        resetn |=> statusWord[XCD_BIT] == $past(live.crossCd))
        else $error("pair C D crossover bit wrong");

    cross_ab_a: assert property (
        resetn |=> statusWord[XAB_BIT] == $past(live.crossAb))
        else $error("pair A B crossover bit wrong");

    gig_mask_a: assert property (
        resetn |=> statusWord[GMASK_BIT] == $past(live.gigMasking && live.negRunning))
        else $error("gigabit masking bit wrong");

    sleep_bit_a: assert property (
        resetn |=> statusWord[SLEEP_BIT] == $past(live.asleep))
        else $error("sleep bit wrong");

    // Reset values are checked with the default disable switched off for that assertion.
    pol10_reset_a: assert property (
        disable iff (1'b0) !resetn |=> statusWord[POL10_BIT])
        else $error("ten megabit polarity not one after reset");

    pol10_live_a: assert property (
        resetn |=> statusWord[POL10_BIT] == $past(live.pol10Ok))
        else $error("ten megabit polarity bit wrong");

    jabber_gate_a: assert property (
        live.rate != RATE_10M |=> !statusWord[JABBER_BIT])
        else $error("jabber shown away from ten megabit");

    jabber_mirror_a: assert property (
        resetn |=> statusWord[JABBER_BIT] == $past(live.jabber && live.rate == RATE_10M))
        else $error("jabber bit does not mirror detector");

    enable_reset_a: assert property (
        disable iff (1'b0) !resetn |=> enableR == ENABLE_RESET)
        else $error("enable register not cleared by reset");

    enable_hold_a: assert property (
        !wrEnable |=> $stable(enableR))
        else $error("enable register changed without a write");

    reserved_bits_a: assert property (
        !enableR[9] && !enableR[7])
        else $error("reserved enable bit set");

    enable_read_a: assert property (
        setupPh && !pwrite && regIdx == IDX_IRQ_ENABLE && addrOk |=> prdata[15:0] == $past(enableR))
        else $error("enable read data wrong");

    // Pending bits and the interrupt level they drive.
    pend_clear_a: assert property (
        rdPend && evtVec == 16'h0000 |=> pendR == 16'h0000)
        else $error("pending bits not cleared by read");

    pend_read_a: assert property (
        setupPh && !pwrite && regIdx == IDX_EVENT_PEND && addrOk |=> prdata[15:0] == $past(pendR))
        else $error("pending read data wrong");

    irq_raise_a: assert property (
        (evtVec & enableR) != 16'h0000 && !wrEnable |=> irq)
        else $error("enabled event gave no interrupt");

    config_reset_a: assert property (
        disable iff (1'b0) !resetn |=> configR == CONFIG_RESET && intPin)
        else $error("pin not active low after reset");

    pin_high_a: assert property (
        irq && !configR[INT_POL_BIT] ##1 irq && !configR[INT_POL_BIT] |-> intPin)
        else $error("active high pin wrong");

    // Bus answer: refused accesses flag an error and the upper half reads zero.
    slverr_flag_a: assert property (
        setupPh && !addrOk |=> pslverr)
        else $error("refused access without error");

    rdata_upper_a: assert property (
        prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");

endmodule

// ===== src/phy_status_pkg.sv
// Register map, field positions, reset values and carrier types for the link status block.
package phy_status_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_LINK_STATE = 10'h011;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h012;
    localparam logic [9:0] IDX_EVENT_PEND = 10'h013;
    localparam logic [9:0] IDX_IRQ_CONFIG = 10'h014;

    // Link state summary field positions.
    localparam int RATE_HI     = 15;
    localparam int RATE_LO     = 14;
    localparam int DUPLEX_BIT  = 13;
    localparam int PAGE_BIT    = 12;
    localparam int RESOLV_BIT  = 11;
    localparam int LINK_BIT    = 10;
    localparam int XCD_BIT     = 9;
    localparam int XAB_BIT     = 8;
    localparam int GMASK_BIT   = 7;
    localparam int SLEEP_BIT   = 6;
    localparam int CHPOL_HI    = 5;
    localparam int CHPOL_LO    = 2;
    localparam int POL10_BIT   = 1;
    localparam int JABBER_BIT  = 0;

    // Rate encodings.
    localparam logic [1:0] RATE_10M  = 2'h0;
    localparam logic [1:0] RATE_100M = 2'h1;
    localparam logic [1:0] RATE_1G   = 2'h2;

    // Event positions shared by the enable and pending registers.
    localparam int EV_NEG_ERR  = 15;
    localparam int EV_RATE     = 14;
    localparam int EV_DUPLEX   = 13;
    localparam int EV_PAGE     = 12;
    localparam int EV_NEG_DONE = 11;
    localparam int EV_LINK     = 10;
    localparam int EV_FALSE_CS = 8;
    localparam int EV_CROSS    = 6;
    localparam int EV_DOWNSHFT = 5;
    localparam int EV_DOZE     = 4;
    localparam int EV_WAKE     = 3;
    localparam int EV_MAC_ERR  = 2;
    localparam int EV_POLARITY = 1;
    localparam int EV_JABBER   = 0;

    // Reset values and writable masks.
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_WMASK = 16'hfd7f;
    localparam logic [15:0] PEND_RESET   = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h2000;
    localparam logic [15:0] CONFIG_WMASK = 16'h2000;
    localparam int          INT_POL_BIT  = 13;

    // Live state from the transceiver core.
    typedef struct packed {
        logic [1:0] rate;
        logic       fullDuplex;
        logic       negDone;
        logic       negEnabled;
        logic       negRunning;
        logic       linkUp;
        logic       crossCd;
        logic       crossAb;
        logic       gigMasking;
        logic       asleep;
        logic [3:0] chanPolRev;
        logic       pol10Ok;
        logic       jabber;
    } live_status_t;

    // One-cycle event pulses from the transceiver core.
    typedef struct packed {
        logic negError;
        logic pageRx;
        logic falseCarrier;
        logic downshift;
        logic wakePacket;
        logic macIfError;
    } ext_events_t;

endpackage

// ===== test/test_phy_status_and_irq_enable.sv
// Self-checking bench for the link state summary and event enable block.
`timescale 1ns/1ps
module test_phy_status_and_irq_enable;
    import phy_status_pkg::*;

    logic         mclk    = 1'b0;
    logic         resetn  = 1'b0;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [11:0]  paddr   = 12'h000;
    logic [31:0]  pwdata  = 32'h0;
    logic [3:0]   pstrb   = 4'h0;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    live_status_t live    = live_status_t'(17'h01002);
    ext_events_t  extEv   = '0;
    logic         irq;
    logic         intPin;
    int           n_mismatch = 0;
    int           tests_run  = 0;
    int           cycles     = 0;
    logic [31:0]  rd;
    logic         err;
    // Live vectors and the summary each must produce.
    logic [16:0]  vin[3] = '{17'h17ee9, 17'h09d3f, 17'h040bf};
    logic [15:0]  vex[3] = '{16'haee8, 16'h4502, 16'h2803};
    int           evPos[6] = '{15, 12, 8, 5, 3, 2};

    phy_status_and_irq_enable u_phy_status_and_irq_enable (
        .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .live(live),
        .extEv(extEv), .irq(irq), .intPin(intPin)
    );

    // Free-running 250 MHz clock.
    always #2 mclk = ~mclk;

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A run of a few hundred cycles; the ceiling only catches a hung handshake.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkFlag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       input logic [3:0] strb);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        pstrb   <= strb;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
        apb(1'b0, addr, 32'h0, 4'h0);
        chkWord(rd, exp);
        chkFlag(err, expErr);
    endtask

    // Flags are sampled just after the edge so that its updates have landed.
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(input ext_events_t ev);
        @(posedge mclk);
        extEv <= ev;
        @(posedge mclk);
        extEv <= '0;
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        idle(2);
        chkFlag(irq, 1'b0);
        chkFlag(intPin, 1'b1);
        rdChk(12'h044, 32'h0002, 1'b0);
        rdChk(12'h048, 32'h0000, 1'b0);
        rdChk(12'h050, 32'h2000, 1'b0);
        // Live vectors cover each field, including the gated ones; nothing is enabled.
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            live <= live_status_t'(vin[i]);
            idle(3);
            rdChk(12'h044, {16'h0, vex[i]}, 1'b0);
            chkFlag(irq, 1'b0);
        end
        // Page latch clears on a summary read, jabber does not.
        apb(1'b0, 12'h04c, 32'h0, 4'h0);
        pulse(ext_events_t'(6'h10));
        idle(2);
        rdChk(12'h044, 32'h3803, 1'b0);
        rdChk(12'h044, 32'h2803, 1'b0);
        // Each pulsed event pends while masked and interrupts once enabled.
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'h04c, 32'h0, 4'h0);
            pulse(ext_events_t'(6'h20 >> i));
            idle(2);
            chkFlag(irq, 1'b0);
            apb(1'b1, 12'h048, 32'h1 << evPos[i], 4'h3);
            idle(2);
            chkFlag(irq, 1'b1);
            chkFlag(intPin, 1'b0);
            rdChk(12'h04c, 32'h1 << evPos[i], 1'b0);
            idle(2);
            chkFlag(irq, 1'b0);
        end
        // A link change seen on the live inputs.
        apb(1'b1, 12'h048, 32'h0400, 4'h3);
        @(posedge mclk);
        live <= live_status_t'(17'h044bf);
        idle(3);
        chkFlag(irq, 1'b1);
        rdChk(12'h04c, 32'h0400, 1'b0);
        rdChk(12'h044, 32'h3c03, 1'b0);
        // Active-high pin after the polarity bit is cleared.
        apb(1'b1, 12'h050, 32'h0, 4'h3);
        apb(1'b1, 12'h048, 32'h8000, 4'h3);
        pulse(ext_events_t'(6'h20));
        idle(3);
        chkFlag(intPin, 1'b1);
        apb(1'b0, 12'h04c, 32'h0, 4'h0);
        idle(3);
        chkFlag(intPin, 1'b0);
        // Reserved enable bits stay zero; the strobe limits a write to its lane.
        apb(1'b1, 12'h048, 32'hffff, 4'h3);
        rdChk(12'h048, 32'hfd7f, 1'b0);
        apb(1'b1, 12'h048, 32'h0, 4'h1);
        rdChk(12'h048, 32'hfd00, 1'b0);
        // Refused and ignored accesses.
        rdChk(12'h060, 32'h0, 1'b1);
        rdChk(12'h046, 32'h0, 1'b1);
        apb(1'b1, 12'h044, 32'hffff, 4'h3);
        chkFlag(err, 1'b0);
        rdChk(12'h044, 32'h2c03, 1'b0);
        close_out();
    end
endmodule
